/* File: bench/adc_conversion_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the design package and the clock source model.
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
    logic clock, rst, cc, csl_n, csh, rd_n, wr_n, oe, sync_n, pwr_dn, xref;
    logic rw_pin = 1'b0;
    logic [11:0] din, dout, ws;
    logic [1:0] tvs;
    adc_seq_pkg::inputs_s ain;
    int n_errors = 0;
    int checked = 0;

    conv_clock_source src_u (.clock(clock), .conversion_clock(cc));
    adc_conversion_sequencer dut_u (.clock(clock), .rst(rst),
        .conversion_clock(cc), .analog_codes(ain),
        .chip_select_low_active_n(csl_n), .chip_select_high_active(csh),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(din),
        .data_out(dout), .data_oe(oe), .sync_n(sync_n), .power_down(pwr_dn),
        .test_voltage_select(tvs), .external_reference(xref));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ************************************************************
    // Bus access and checking
    // ************************************************************
    task automatic chk(logic [11:0] got, logic [11:0] exp, string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Waits for the conversion clock to reach lvl, at most 100 cycles.
    task automatic cc_to(logic lvl);
        int n;
        n = 0;
        while (cc !== lvl && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (cc !== lvl) begin
            n_errors++;
            $display("BAD %0t conversion clock stuck", $time);
            test_done();
        end
    endtask

    task automatic cc_fall();
        cc_to(1'b1);
        cc_to(1'b0);
    endtask

    // Strobe held over two edges, so the answer has landed on release.
    task automatic bus(logic wr, logic [11:0] d);
        @(posedge clock);
        #1;
        csl_n = 1'b0;
        csh = 1'b1;
        wr_n = !wr;
        rd_n = wr || rw_pin;
        din = d;
        repeat (2) @(posedge clock);
        #1;
        csl_n = 1'b1;
        csh = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
    endtask

    task automatic wr(logic [1:0] a, logic [9:0] v);
        bus(1'b1, {a, v});
        @(posedge clock);
        #1;
    endtask

    task automatic rd(logic [11:0] exp);
        bus(1'b0, 12'h000);
        chk(dout, exp, "readback");
        chk({11'h000, oe}, 12'h001, "enable on");
        @(posedge clock);
        #1;
        chk({11'h000, oe}, 12'h000, "enable off");
    endtask

    // Restart, skip the latency, then read one word per fall.
    task automatic seq(logic [9:0] zero_val, logic [9:0] one_val, int nch,
                       logic [47:0] e);
        cc_to(1'b0);
        cc_to(1'b1);
        wr(2'h0, zero_val);
        wr(2'h1, one_val | 10'h002);
        repeat (5) cc_fall();
        for (int j = 0; j < 12; j++) begin
            cc_fall();
            repeat (6) @(posedge clock);
            bus(1'b0, 12'h000);
            chk(dout, e[47-12*(j%nch) -: 12], "code");
            // Word j is pushed 6 + j falls after restart, so channel one
            // is first marked once j passes the channel count.
            ws = (nch > 1 && j % nch == 0 && j > nch) ? 12'h000 : 12'h001;
            chk({11'h000, sync_n}, ws, "marker");
        end
        $display("test cfg %h fmt %h done", zero_val, one_val);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        rst = 1'b1;
        csl_n = 1'b1;
        csh = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        din = 12'h000;
        ain = {12'hfff, 12'h001, 12'h800, 12'h000};
        repeat (10) @(posedge clock);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge clock);
        chk({tvs, pwr_dn, xref, 8'h00}, 12'h000, "reset pins");
        wr(2'h0, 10'h3a5);
        chk({tvs, pwr_dn, xref, 8'h00}, 12'hf00, "mode pins");
        wr(2'h2, 10'h155);
        wr(2'h1, 10'h300);
        rd(12'h3a5);
        rd(12'h700);
        wr(2'h1, 10'h001);
        wr(2'h1, 10'h200);
        rd(12'h020);
        rd(12'h600);
        wr(2'h1, 10'h000);
        // Read/write pin mode: the read strobe stays high throughout.
        rw_pin = 1'b1;
        wr(2'h1, 10'h240);
        rd(12'h020);
        rd(12'h640);
        wr(2'h1, 10'h000);
        rw_pin = 1'b0;
        $display("test registers done");
        seq(10'h000, 10'h000, 1, {12'hfff, 36'h0});
        seq(10'h000, 10'h080, 1, {12'h7ff, 36'h0});
        seq(10'h010, 10'h000, 1, {12'h800, 36'h0});
        seq(10'h010, 10'h080, 1, {12'h000, 36'h0});
        seq(10'h018, 10'h000, 1, {12'h000, 36'h0});
        seq(10'h018, 10'h080, 1, {12'h800, 36'h0});
        seq(10'h020, 10'h000, 1, {12'hfff, 36'h0});
        seq(10'h098, 10'h000, 4, {48'hfff001800000});
        seq(10'h090, 10'h000, 3, {36'hfff001800, 12'h0});
        seq(10'h0c8, 10'h000, 2, {24'hfffc00, 24'h0});
        test_done();
    end

    initial begin
        #100us;
        n_errors++;
        $display("BAD %0t run stalled", $time);
        test_done();
    end
endmodule // adc_conversion_sequencer_tb_top

/* File: bench/conv_clock_source.sv */
// Far-side model: the host's free-running conversion clock.
// Assumes the system clock runs at 250 MHz and the bench watches edges.
`timescale 1ns/1ps
module conv_clock_source #(
    parameter int HALF_CYCLES = 21
) (
    input wire logic clock,
    output logic conversion_clock
);
    // Near 6 MHz, so even one channel stays inside the rated rate.
    // Edges move just after a system clock edge, like every other input.
    initial begin
        conversion_clock = 1'b1;
        forever begin
            repeat (HALF_CYCLES) @(posedge clock);
            #1;
            conversion_clock = ~conversion_clock;
        end
    end
endmodule // conv_clock_source

/* File: hdl/adc_conversion_sequencer.sv */
// Digital side of a four-input simultaneous-sampling pipelined converter.
// Assumes all pins are synchronous to clock and clock is much faster
// than the conversion clock.
//
// Operation
// - Every conversion clock falling edge outside power down starts a new conversion.
// - A result appears five conversion clock cycles after its start.
// - First channel-one marker waits seven plus channel count cycles.
// - Each fall yields a fresh value readable with the read strobe.
// - Marker goes low with a channel one result read and holds until the next result read.
// - Marker stays inactive when one channel is selected.
// - Multichannel results come in ascending order, then wrap to one.
// - Binary format: FFF full scale, 800 mid, 000 negative full.
// - Twos complement: 7FF full scale, 000 mid, 800 negative full.
// - Two ten-bit control registers select the operating mode.
// - Register zero holds test, scan, diff, channel, power, reference.
// - Register one holds readback, offset, format, pin mode, resets.
// - All four inputs are sampled at once, single or differential.
// - Write carries value on bits 9:0, address on bits 11:10.
`timescale 1ns/1ps
module adc_conversion_sequencer #(
    parameter int FIFO_DEPTH = adc_seq_pkg::FIFO_DEPTH,
    parameter int PIPE_DEPTH = adc_seq_pkg::PIPE_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic conversion_clock,
    input wire adc_seq_pkg::inputs_s analog_codes,
    input wire logic chip_select_low_active_n,
    input wire logic chip_select_high_active,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [11:0] data_in,
    output logic [11:0] data_out,
    output logic data_oe,
    output logic sync_n,
    output logic power_down,
    output logic [1:0] test_voltage_select,
    output logic external_reference
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b01,
        ACC_HELD = 2'b10
    } access_e;

    access_e acc_state, next_acc_state;
    logic [9:0] mode_control_zero, next_mode_control_zero;
    logic [9:0] mode_control_one, next_mode_control_one;
    logic [11:0] next_data_out;
    logic next_data_oe, next_sync_n, rb_sel, next_rb_sel;
    logic seq_restart, next_seq_restart;
    logic conv_prev, conv_fall, active;
    logic [1:0] scan_idx, next_scan_idx;
    logic [3:0] holdoff, next_holdoff;
    logic [4:0] cfg;
    logic [2:0] nch;
    logic multi, holdoff_done;
    logic selected, combined_read_access, write_access;
    logic [11:0] sampled;
    adc_seq_pkg::result_s pipe_in, pipe_out, fifo_in, fifo_out;
    logic pipe_valid, fifo_ready, fifo_valid, fifo_pop;

    function automatic logic [11:0] diff_code(logic [11:0] p,
                                              logic [11:0] m);
        logic signed [12:0] d;
        d = $signed({1'b0, p}) - $signed({1'b0, m});
        return 12'(d >>> 1) + adc_seq_pkg::MID_CODE;
    endfunction

    assign cfg = mode_control_zero[adc_seq_pkg::ZERO_CFG_HI:
                                   adc_seq_pkg::ZERO_CFG_LO];
    assign nch = adc_seq_pkg::chan_count(cfg);
    assign multi = nch != 3'h1;
    assign holdoff_done = holdoff == 4'(adc_seq_pkg::SYNC_BASE) + 4'(nch);
    assign power_down = mode_control_zero[adc_seq_pkg::ZERO_POWER_DOWN];
    assign test_voltage_select =
        mode_control_zero[adc_seq_pkg::ZERO_TEST_HI:
                          adc_seq_pkg::ZERO_TEST_LO];
    assign external_reference = mode_control_zero[adc_seq_pkg::ZERO_VREF];

    // ************************************************************
    // Conversion clock edge and sampling
    // ************************************************************
    // Power down halts conversions; the bus still answers.
    assign conv_fall = conv_prev && !conversion_clock;
    assign active = conv_fall && !power_down;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            conv_prev <= 1'b0;
        end else begin
            conv_prev <= conversion_clock;
        end
    end

    // All four inputs are held together; the slot picks one view.
    always_comb begin
        unique case (adc_seq_pkg::slot_source(cfg, scan_idx))
            adc_seq_pkg::SRC_AP: sampled = analog_codes.ainp;
            adc_seq_pkg::SRC_AM: sampled = analog_codes.ainm;
            adc_seq_pkg::SRC_BP: sampled = analog_codes.binp;
            adc_seq_pkg::SRC_BM: sampled = analog_codes.binm;
            adc_seq_pkg::SRC_DA:
                sampled = diff_code(analog_codes.ainp, analog_codes.ainm);
            adc_seq_pkg::SRC_DB:
                sampled = diff_code(analog_codes.binp, analog_codes.binm);
            default: sampled = adc_seq_pkg::MID_CODE;
        endcase
    end

    // ************************************************************
    // Channel sequence and marker holdoff
    // ************************************************************
    always_comb begin
        next_scan_idx = scan_idx;
        next_holdoff = holdoff;
        if (seq_restart) begin
            next_scan_idx = 2'h0;
            next_holdoff = 4'h0;
        end else if (active) begin
            next_scan_idx = (3'(scan_idx) == nch - 3'h1) ? 2'h0
                            : scan_idx + 2'h1;
            if (!holdoff_done) begin
                next_holdoff = holdoff + 4'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scan_idx <= 2'h0;
            holdoff <= 4'h0;
        end else begin
            scan_idx <= next_scan_idx;
            holdoff <= next_holdoff;
        end
    end

    assign pipe_in = '{first: scan_idx == 2'h0, code: sampled};

    conv_pipeline #(
        .WIDTH($bits(adc_seq_pkg::result_s)),
        .DEPTH(PIPE_DEPTH)
    ) u_pipe (
        .clock(clock),
        .rst(rst),
        .advance(active),
        .flush(seq_restart),
        .in_data(pipe_in),
        .out_valid(pipe_valid),
        .out_data(pipe_out)
    );

    // The marker flag is only kept in multichannel mode once the
    // holdoff has run out. A full buffer drops the newest result, as
    // the converter itself cannot be stalled.
    assign fifo_in = '{first: pipe_out.first && multi && holdoff_done,
                       code: pipe_out.code};

    result_fifo #(
        .WIDTH($bits(adc_seq_pkg::result_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .flush(seq_restart),
        .in_valid(pipe_valid && fifo_ready),
        .in_data(fifo_in),
        .in_ready(fifo_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_out),
        .out_ready(fifo_pop)
    );

    // ************************************************************
    // Parallel port and control registers
    // ************************************************************
    assign selected = !chip_select_low_active_n
                      && chip_select_high_active;
    assign write_access = selected && !write_strobe_n;
    assign combined_read_access =
        mode_control_one[adc_seq_pkg::ONE_RW_MODE]
        ? selected && write_strobe_n
        : selected && !read_strobe_n;
    assign fifo_pop = acc_state == ACC_IDLE && !write_access
                      && combined_read_access && fifo_valid
                      && !mode_control_one[adc_seq_pkg::ONE_READBACK];

    always_comb begin
        next_acc_state = acc_state;
        next_mode_control_zero = mode_control_zero;
        next_mode_control_one = mode_control_one;
        next_data_out = data_out;
        next_data_oe = data_oe;
        next_sync_n = sync_n;
        next_rb_sel = rb_sel;
        next_seq_restart = 1'b0;
        unique case (acc_state)
            ACC_IDLE: begin
                if (write_access) begin
                    next_acc_state = ACC_HELD;
                    if (data_in[11:10] == adc_seq_pkg::ADDR_ZERO) begin
                        next_mode_control_zero = data_in[9:0];
                        next_seq_restart =
                            data_in[adc_seq_pkg::ZERO_CFG_HI:
                                    adc_seq_pkg::ZERO_CFG_LO] != cfg;
                    end else if (data_in[11:10]
                                 == adc_seq_pkg::ADDR_ONE) begin
                        next_mode_control_one = data_in[9:0];
                        next_mode_control_one[adc_seq_pkg::ONE_SEQ_RST] =
                            1'b0;
                        next_mode_control_one[adc_seq_pkg::ONE_FULL_RST] =
                            1'b0;
                        next_seq_restart =
                            data_in[adc_seq_pkg::ONE_SEQ_RST]
                            || data_in[adc_seq_pkg::ONE_FULL_RST];
                        if (data_in[adc_seq_pkg::ONE_FULL_RST]) begin
                            next_mode_control_zero = adc_seq_pkg::ZERO_RESET;
                            next_mode_control_one = adc_seq_pkg::ONE_RESET;
                        end
                    end
                end else if (combined_read_access) begin
                    next_acc_state = ACC_HELD;
                    next_data_oe = 1'b1;
                    if (mode_control_one[adc_seq_pkg::ONE_READBACK]) begin
                        next_data_out = rb_sel
                            ? {adc_seq_pkg::ADDR_ONE, mode_control_one}
                            : {adc_seq_pkg::ADDR_ZERO, mode_control_zero};
                        next_rb_sel = !rb_sel;
                    end else if (fifo_valid) begin
                        next_data_out = fifo_out.code ^ {
                            mode_control_one[adc_seq_pkg::ONE_FORMAT],
                            11'h000};
                        next_sync_n = !fifo_out.first;
                    end
                end
            end
            ACC_HELD: begin
                if (!write_access && !combined_read_access) begin
                    next_acc_state = ACC_IDLE;
                    next_data_oe = 1'b0;
                end
            end
        endcase
        if (next_seq_restart || !multi) begin
            next_sync_n = 1'b1;
        end
        if (!mode_control_one[adc_seq_pkg::ONE_READBACK]) begin
            next_rb_sel = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_state <= ACC_IDLE;
            mode_control_zero <= adc_seq_pkg::ZERO_RESET;
            mode_control_one <= adc_seq_pkg::ONE_RESET;
            data_out <= 12'h000;
            data_oe <= 1'b0;
            sync_n <= 1'b1;
            rb_sel <= 1'b0;
            seq_restart <= 1'b1;
        end else begin
            acc_state <= next_acc_state;
            mode_control_zero <= next_mode_control_zero;
            mode_control_one <= next_mode_control_one;
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            sync_n <= next_sync_n;
            rb_sel <= next_rb_sel;
            seq_restart <= next_seq_restart;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    seq_wrap_a: assert property (
        @(posedge clock) disable iff (rst)
        active && !seq_restart && 3'(scan_idx) == nch - 3'h1
        |=> scan_idx == 2'h0)
        else $error("sequence did not wrap to channel one");

    seq_step_a: assert property (
        @(posedge clock) disable iff (rst)
        active && !seq_restart && 3'(scan_idx) < nch - 3'h1
        |=> scan_idx == $past(scan_idx) + 2'h1)
        else $error("sequence did not step in ascending order");

    single_quiet_a: assert property (
        @(posedge clock) disable iff (rst)
        !multi |=> sync_n)
        else $error("marker active in single channel mode");

    restart_seq_a: assert property (
        @(posedge clock) disable iff (rst)
        seq_restart |=> scan_idx == 2'h0 && holdoff == 4'h0 && sync_n)
        else $error("sequence not restarted at channel one");

    marker_holdoff_a: assert property (
        @(posedge clock) disable iff (rst)
        !sync_n |-> holdoff_done && multi)
        else $error("marker asserted before holdoff ran out");

    cr_write_a: assert property (
        @(posedge clock) disable iff (rst)
        acc_state == ACC_IDLE && write_access
        && data_in[11:10] == adc_seq_pkg::ADDR_ZERO
        |=> mode_control_zero == $past(data_in[9:0]))
        else $error("register zero write not loaded");

    read_format_a: assert property (
        @(posedge clock) disable iff (rst)
        fifo_pop && mode_control_one[adc_seq_pkg::ONE_FORMAT]
        |=> data_out == ($past(fifo_out.code) ^ 12'h800) && data_oe)
        else $error("twos complement code not presented");

endmodule // adc_conversion_sequencer

/* File: hdl/conv_pipeline.sv */
// Fixed-latency delay line that models the converter pipeline.
// Assumes advance pulses once per conversion clock falling edge.
`timescale 1ns/1ps
module conv_pipeline #(
    parameter int WIDTH = 13,
    parameter int DEPTH = adc_seq_pkg::PIPE_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic advance,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] stage [DEPTH];
    logic [DEPTH-1:0] valid;
    logic [DEPTH-1:0] next_valid;
    logic next_out_valid;
    logic [3:0] fill;

    always_comb begin
        next_valid = valid;
        next_out_valid = 1'b0;
        if (flush) begin
            next_valid = '0;
        end else if (advance) begin
            next_valid = {valid[DEPTH-2:0], 1'b1};
            next_out_valid = valid[DEPTH-1];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            valid <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else begin
            valid <= next_valid;
            out_valid <= next_out_valid;
            if (advance) begin
                out_data <= stage[DEPTH-1];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (advance) begin
            stage[0] <= in_data;
            for (int i = 1; i < DEPTH; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    // Counts falling edges since the last flush, for checking only.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fill <= 4'h0;
        end else if (flush) begin
            fill <= 4'h0;
        end else if (advance && fill != 4'hf) begin
            fill <= fill + 4'h1;
        end
    end

    latency_five_a: assert property (
        @(posedge clock) disable iff (rst)
        out_valid |-> fill > 4'(DEPTH))
        else $error("result left the pipeline too early");

    sample_taken_a: assert property (
        @(posedge clock) disable iff (rst)
        advance && !flush |=> valid[0])
        else $error("falling edge did not start a conversion");

endmodule // conv_pipeline

/* File: hdl/result_fifo.sv */
// Result buffer between the pipeline and the parallel read port.
// Assumes a single clock; flush empties it in one cycle.
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = adc_seq_pkg::FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr + AW'(push);
        next_rd_ptr = rd_ptr + AW'(pop);
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    fifo_bound_a: assert property (
        @(posedge clock) disable iff (rst)
        count <= (AW+1)'(DEPTH) && (count != '0 || !out_valid))
        else $error("fifo count out of range");

endmodule // result_fifo

/* File: shared/adc_seq_pkg.sv */
// Constants, types and channel decoding for the conversion sequencer.
// Assumes every user names items as adc_seq_pkg::name.
package adc_seq_pkg;

    // ************************************************************
    // Widths, depths and timing counts
    // ************************************************************
    localparam int DATA_W = 12;
    localparam int CFG_W = 10;
    localparam int PIPE_DEPTH = 5;
    localparam int SYNC_BASE = 7;
    localparam int FIFO_DEPTH = 16;

    // ************************************************************
    // Register addresses, field positions and reset values
    // ************************************************************
    localparam logic [1:0] ADDR_ZERO = 2'h0;
    localparam logic [1:0] ADDR_ONE = 2'h1;
    localparam int ADDR_LO = 10;
    localparam int ZERO_TEST_HI = 9;
    localparam int ZERO_TEST_LO = 8;
    localparam int ZERO_CFG_HI = 7;
    localparam int ZERO_CFG_LO = 3;
    localparam int ZERO_POWER_DOWN = 2;
    localparam int ZERO_VREF = 0;
    localparam int ONE_READBACK = 9;
    localparam int ONE_FORMAT = 7;
    localparam int ONE_RW_MODE = 6;
    localparam int ONE_SEQ_RST = 1;
    localparam int ONE_FULL_RST = 0;
    localparam logic [9:0] ZERO_RESET = 10'h020;
    localparam logic [9:0] ONE_RESET = 10'h000;
    localparam logic [11:0] MID_CODE = 12'h800;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        SRC_AP = 3'h0,
        SRC_AM = 3'h1,
        SRC_BP = 3'h2,
        SRC_BM = 3'h3,
        SRC_DA = 3'h4,
        SRC_DB = 3'h5
    } source_e;

    typedef struct packed {
        logic [11:0] ainp;
        logic [11:0] ainm;
        logic [11:0] binp;
        logic [11:0] binm;
    } inputs_s;

    typedef struct packed {
        logic first;
        logic [11:0] code;
    } result_s;

    // ************************************************************
    // Channel configuration decoding
    // ************************************************************
    // The cfg argument is scan, diff count (2 bits) and channel pick.
    function automatic logic [2:0] chan_count(logic [4:0] cfg);
        case (cfg)
            5'h11, 5'h15, 5'h19: return 3'h2;
            5'h12, 5'h16: return 3'h3;
            5'h13: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction

    // Undefined codes fall back to the first single-ended input.
    function automatic source_e slot_source(logic [4:0] cfg,
                                            logic [1:0] idx);
        if (!cfg[4]) begin
            if (cfg[3:2] == 2'h0)
                return source_e'({1'b0, cfg[1:0]});
            if (cfg[3:2] == 2'h1 && !cfg[1])
                return cfg[0] ? SRC_DB : SRC_DA;
            return SRC_AP;
        end
        case (cfg[3:0])
            4'h1, 4'h2, 4'h3: return source_e'({1'b0, idx});
            4'h5: return (idx == 2'h0) ? SRC_AP : SRC_DB;
            4'h6: return (idx == 2'h2) ? SRC_DB : source_e'({1'b0, idx});
            4'h9: return (idx == 2'h0) ? SRC_DA : SRC_DB;
            default: return SRC_AP;
        endcase
    endfunction

endpackage
